// file: verilog/ecpp_pkg.sv
// constants and types of the extended capabilities parallel port
`default_nettype none
package ecpp_pkg;
   localparam int          WORD_W     = 8;
   localparam int          FIFO_DEPTH = 16;
   localparam logic [10:0] OFS_DATA   = 11'h000;
   localparam logic [10:0] OFS_STAT   = 11'h001;
   localparam logic [10:0] OFS_CTRL   = 11'h002;
   localparam logic [10:0] OFS_FIFO   = 11'h400;
   localparam logic [10:0] OFS_CFGB   = 11'h401;
   localparam logic [10:0] OFS_ECR    = 11'h402;
   localparam logic [2:0]  MODE_SPP   = 3'h0;
   localparam logic [2:0]  MODE_PS2   = 3'h1;
   localparam logic [2:0]  MODE_COMPAT_FIFO_PORT = 3'h2;
   localparam logic [2:0]  MODE_ECP   = 3'h3;
   localparam logic [2:0]  MODE_TEST  = 3'h6;
   localparam logic [2:0]  MODE_CFG   = 3'h7;
   localparam logic [7:0]  CFGA_VALUE = 8'h10;
   localparam logic [7:0]  DATA_RESET = 8'h00;
   localparam logic [5:0]  CTRL_RESET = 6'h00;
   localparam logic [2:0]  MODE_RESET = 3'h0;
   localparam logic        MASK_RESET = 1'b1;
   localparam logic        DMA_RESET  = 1'b0;
   localparam logic        SERV_RESET = 1'b1;
   localparam int          CTRL_STB   = 0;
   localparam int          CTRL_AFD   = 1;
   localparam int          CTRL_INIT  = 2;
   localparam int          CTRL_SEL   = 3;
   localparam int          CTRL_DIR   = 5;

   typedef struct packed {
      logic              cmd;
      logic [WORD_W-1:0] data;
   } ecpp_word_t;

   typedef struct packed {
      logic peripheral_acknowledge;
      logic peripheral_clock_line;
      logic reverse_acknowledge_line;
      logic select;
      logic peripheral_request_line;
   } ecpp_pin_in_t;

   typedef struct packed {
      logic host_clock_line;
      logic host_acknowledge_line;
      logic reverse_request_line;
      logic mode_select_line;
   } ecpp_pin_out_t;

   typedef enum logic [1:0] {
      F_IDLE  = 2'b00,
      F_SETUP = 2'b01,
      F_STB   = 2'b10,
      F_HOLD  = 2'b11
   } ecpp_fwd_t;

   typedef enum logic [1:0] {
      R_IDLE = 2'b00,
      R_REQ  = 2'b01,
      R_ACK  = 2'b10
   } ecpp_rev_t;
endpackage
`default_nettype wire

// file: verilog/ecpp_top.sv
// extended capabilities parallel port: shared fifo and port engines
// Operation
// RULE1 - port word is one byte wide
// RULE2 - one shared sixteen byte fifo for all
// RULE3 - status and control reachable in every mode
// RULE4 - no negotiation; dma burst both directions
// RULE5 - compat handshake runs from fifo automatically
// RULE6 - run-length byte repeats next byte, not data
// RULE7 - compression optional, not built here
// RULE8 - strobe falling edge latches forward byte
// RULE9 - peripheral drops ack when ready again
// RULE10 - peripheral ack marks reverse command or data
// RULE11 - peripheral clock low marks valid reverse data
// RULE12 - host ack requests each reverse byte
// RULE13 - forward host ack tells command or data
// RULE14 - reverse ack low answers reverse request
// RULE15 - drive data only while reverse ack allows
// RULE16 - reverse request low selects reverse direction
// RULE17 - peripheral drives bus only when permitted
// RULE18 - peripheral request raises error interrupt
// RULE19 - peripheral request is only a hint
// RULE20 - mode select held deasserted in ecp mode
// RULE21 - mode 011 is ecp, 000 compat
// RULE22 - modes 000 and 010 always drive out
// RULE23 - full and empty flags track fifo
`timescale 1ns/1ns
`default_nettype none

module ecpp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic                       clock_i,
   input  wire logic                       reset_i,
   input  wire logic                       flush_i,
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [WIDTH-1:0]                out_data_o,
   output logic [$clog2(DEPTH+1)-1:0]      count_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready_o  = cnt_q != CW'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem_q[rd_q];
   assign count_o     = cnt_q;
   assign push        = in_valid_i & in_ready_o & ~flush_i;
   assign pop         = out_valid_o & out_ready_i & ~flush_i;

   always_comb begin
      wr_d  = flush_i ? '0 : wr_q + AW'(push);
      rd_d  = flush_i ? '0 : rd_q + AW'(pop);
      cnt_d = flush_i ? '0 : cnt_q + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end
   always_ff @(posedge clock_i) begin
      if (push) mem_q[wr_q] <= in_data_i;
   end
endmodule

module ecpp_top (
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic [10:0]           io_addr_i,
   input  wire logic                  io_wr_i,
   input  wire logic                  io_rd_i,
   input  wire logic [7:0]            io_wdata_i,
   output logic [7:0]                 io_rdata_o,
   input  wire logic                  dma_ack_i,
   output logic                       dma_req_o,
   input  wire ecpp_pkg::ecpp_pin_in_t pins_i,
   input  wire logic [7:0]            port_data_bus_i,
   output logic [7:0]                 port_data_bus_o,
   output logic                       port_data_bus_oe_o,
   output ecpp_pkg::ecpp_pin_out_t    pins_o,
   output logic                       error_irq_o
);
   import ecpp_pkg::*;

   ecpp_pin_in_t   in1_q, in2_q;
   logic [7:0]     pd1_q, pd2_q;
   logic [7:0]     data_q, data_d, last_q, last_d, rdata_q, rdata_d;
   logic [5:0]     ctrl_q, ctrl_d;
   logic [2:0]     mode_q, mode_d;
   logic           mask_q, mask_d, transfer_dma_enable_q, transfer_dma_enable_d, serv_q, serv_d, irq_q, irq_d;
   ecpp_fwd_t      fs_q, fs_d;
   ecpp_word_t     out_q, out_d, cap_q, cap_d, f_out, f_in, h_word;
   logic           stb_q, stb_d;
   ecpp_rev_t      rs_q, rs_d;
   logic           hack_q, hack_d, pend_q, pend_d, rle_q, rle_d;
   logic [6:0]     rep_q, rep_d;
   logic [4:0]     f_cnt;
   logic           f_ready, f_valid, f_pop, r_push, h_push, h_pop, flush;
   logic           ecp_m, test_m, fifo_m, dir, fwd_act, rev_act, reg_wr, fifo_acc, serv_set;

   // two-stage synchronisers on every pin input
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         in1_q <= '1;
         in2_q <= '1;
         pd1_q <= 8'h00;
         pd2_q <= 8'h00;
      end else begin
         in1_q <= pins_i;
         in2_q <= in1_q;
         pd1_q <= port_data_bus_i;
         pd2_q <= pd1_q;
      end
   end

   assign ecp_m   = mode_q == MODE_ECP; // see RULE21
   assign test_m  = mode_q == MODE_TEST;
   assign fifo_m  = (mode_q == MODE_COMPAT_FIFO_PORT) | ecp_m | test_m;
   assign dir     = ctrl_q[CTRL_DIR] & (mode_q != MODE_SPP) & (mode_q != MODE_COMPAT_FIFO_PORT); // see RULE22
   assign fwd_act = (mode_q == MODE_COMPAT_FIFO_PORT) | (ecp_m & ~dir); // see RULE5
   assign rev_act = ecp_m & dir;
   assign flush   = (mode_q == MODE_SPP) | (mode_q == MODE_PS2);
   assign reg_wr  = io_wr_i & ~dma_ack_i;
   assign fifo_acc = dma_ack_i | ((io_addr_i == OFS_FIFO) & fifo_m);
   assign h_push  = io_wr_i & ((fifo_acc & (fwd_act | test_m))
                  | (~dma_ack_i & (io_addr_i == OFS_DATA) & ecp_m & ~dir));
   assign h_word  = '{cmd: ~dma_ack_i & (io_addr_i == OFS_DATA), data: io_wdata_i};
   assign h_pop   = io_rd_i & fifo_acc & (rev_act | test_m) & f_valid;
   assign f_in    = r_push ? cap_q : h_word;
   assign serv_set = transfer_dma_enable_q & ((fwd_act & ~f_valid) | (rev_act & ~f_ready));

   // single shared fifo, one byte plus command tag
   ecpp_fifo #(
      .WIDTH ($bits(ecpp_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo ( // see RULE1 see RULE2
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .flush_i     (flush),
      .in_valid_i  (h_push | r_push),
      .in_ready_o  (f_ready),
      .in_data_i   (f_in),
      .out_valid_o (f_valid),
      .out_ready_i (h_pop | f_pop),
      .out_data_o  (f_out),
      .count_o     (f_cnt)
   );

   // host registers
   always_comb begin
      logic [7:0] rd_val;
      rd_val  = 8'h00;
      data_d  = data_q;
      ctrl_d  = ctrl_q;
      mode_d  = mode_q;
      mask_d  = mask_q;
      transfer_dma_enable_d = transfer_dma_enable_q;
      serv_d  = serv_q;
      last_d  = last_q;
      rdata_d = rdata_q;
      if (reg_wr && io_addr_i == OFS_DATA && (mode_q == MODE_SPP || mode_q == MODE_PS2))
         data_d = io_wdata_i;
      if (reg_wr && io_addr_i == OFS_CTRL) ctrl_d = io_wdata_i[5:0]; // see RULE3
      if (reg_wr && io_addr_i == OFS_ECR) {mode_d, mask_d, transfer_dma_enable_d, serv_d} = io_wdata_i[7:2];
      if (serv_set) serv_d = 1'b1;
      if (h_pop || f_pop) last_d = f_out.data;
      if (fifo_acc && mode_q != MODE_CFG) begin
         rd_val = f_valid ? f_out.data : last_q;
      end else begin
         case (io_addr_i)
            OFS_DATA: rd_val = pd2_q;
            OFS_STAT: rd_val = {~in2_q.peripheral_acknowledge, in2_q.peripheral_clock_line,
                                in2_q.reverse_acknowledge_line, in2_q.select,
                                in2_q.peripheral_request_line, 3'h0}; // see RULE3
            OFS_CTRL: rd_val = {2'h0, ctrl_q};
            OFS_FIFO: rd_val = CFGA_VALUE;
            OFS_CFGB: rd_val = (mode_q == MODE_CFG) ? {1'b0, irq_q, 6'h00} : 8'h00; // see RULE7
            OFS_ECR:  rd_val = {mode_q, mask_q, transfer_dma_enable_q, serv_q, ~f_ready, ~f_valid}; // see RULE23
            default:  rd_val = 8'h00;
         endcase
      end
      if (io_rd_i) rdata_d = rd_val;
      irq_d = ecp_m & ~dir & ~mask_q & ~in2_q.peripheral_request_line; // see RULE18
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         data_q  <= DATA_RESET;
         ctrl_q  <= CTRL_RESET;
         mode_q  <= MODE_RESET;
         mask_q  <= MASK_RESET;
         transfer_dma_enable_q <= DMA_RESET;
         serv_q  <= SERV_RESET;
         last_q  <= 8'h00;
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
      end else begin
         data_q  <= data_d;
         ctrl_q  <= ctrl_d;
         mode_q  <= mode_d;
         mask_q  <= mask_d;
         transfer_dma_enable_q <= transfer_dma_enable_d;
         serv_q  <= serv_d;
         last_q  <= last_d;
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
      end
   end

   // forward engine
   always_comb begin
      fs_d  = fs_q;
      out_d = out_q;
      stb_d = stb_q;
      f_pop = 1'b0;
      unique case (fs_q)
         F_IDLE: if (fwd_act && f_valid) begin
            f_pop = 1'b1;
            out_d = f_out;
            fs_d  = F_SETUP;
         end
         F_SETUP: if (!in2_q.peripheral_acknowledge) begin
            stb_d = 1'b0; // see RULE8
            fs_d  = F_STB;
         end
         F_STB: if (in2_q.peripheral_acknowledge) begin
            stb_d = 1'b1;
            fs_d  = F_HOLD;
         end
         F_HOLD: if (!in2_q.peripheral_acknowledge) fs_d = F_IDLE; // see RULE9
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         fs_q  <= F_IDLE;
         out_q <= '0;
         stb_q <= 1'b1;
      end else begin
         fs_q  <= fs_d;
         out_q <= out_d;
         stb_q <= stb_d;
      end
   end
   // reverse engine with run-length expansion
   always_comb begin
      rs_d   = rs_q;
      hack_d = hack_q;
      cap_d  = cap_q;
      rep_d  = rep_q;
      pend_d = pend_q;
      rle_d  = rle_q;
      r_push = 1'b0;
      unique case (rs_q)
         R_IDLE: begin
            hack_d = 1'b1;
            if (rev_act && !in2_q.reverse_acknowledge_line) begin // see RULE14
               hack_d = 1'b0; // see RULE12
               rs_d   = R_REQ;
            end
         end
         R_REQ: if (!in2_q.peripheral_clock_line) begin // see RULE11
            cap_d  = '{cmd: ~in2_q.peripheral_acknowledge, data: pd2_q}; // see RULE10
            hack_d = 1'b1;
            rs_d   = R_ACK;
            if (!in2_q.peripheral_acknowledge && !pd2_q[7]) begin
               rep_d = pd2_q[6:0]; // see RULE6
               rle_d = 1'b1;
            end else begin
               pend_d = 1'b1;
            end
         end
         R_ACK: begin
            r_push = pend_q;
            if (pend_q && f_ready && rle_q && rep_q != 7'h00) begin
               rep_d = rep_q - 7'h01; // see RULE6
            end else if (pend_q && f_ready) begin
               pend_d = 1'b0;
               rle_d  = 1'b0;
            end else if (!pend_q && in2_q.peripheral_clock_line) begin
               hack_d = ~rev_act;
               rs_d   = rev_act ? R_REQ : R_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rs_q   <= R_IDLE;
         hack_q <= 1'b1;
         cap_q  <= '0;
         rep_q  <= 7'h00;
         pend_q <= 1'b0;
         rle_q  <= 1'b0;
      end else begin
         rs_q   <= rs_d;
         hack_q <= hack_d;
         cap_q  <= cap_d;
         rep_q  <= rep_d;
         pend_q <= pend_d;
         rle_q  <= rle_d;
      end
   end

   // pins and dma request
   always_comb begin
      pins_o.host_clock_line       = fwd_act ? stb_q : ~ctrl_q[CTRL_STB];
      pins_o.host_acknowledge_line = ecp_m ? (dir ? hack_q : ~out_q.cmd) : ~ctrl_q[CTRL_AFD]; // see RULE13
      pins_o.reverse_request_line  = ecp_m ? ~dir : ctrl_q[CTRL_INIT]; // see RULE16
      pins_o.mode_select_line      = ecp_m ? 1'b1 : ~ctrl_q[CTRL_SEL]; // see RULE20
      port_data_bus_o    = fwd_act ? out_q.data : (test_m ? last_q : data_q);
      port_data_bus_oe_o = ~dir & ~(ecp_m & ~in2_q.reverse_acknowledge_line); // see RULE15 see RULE17
      dma_req_o  = transfer_dma_enable_q & ~serv_q & (fwd_act ? f_ready : (rev_act & f_valid)); // see RULE4
   end
   assign io_rdata_o  = rdata_q;
   assign error_irq_o = irq_q;
   a_mode_select_high: assert property (@(posedge clock_i) disable iff (reset_i)
      ecp_m |-> pins_o.mode_select_line) else $error("mode select low in ecp"); // see RULE20
   a_dir_forced_out: assert property (@(posedge clock_i) disable iff (reset_i)
      (mode_q == MODE_SPP || mode_q == MODE_COMPAT_FIFO_PORT) |-> port_data_bus_oe_o)
      else $error("data not driven in forced-out mode"); // see RULE22
   a_bus_permit: assert property (@(posedge clock_i) disable iff (reset_i)
      (ecp_m && port_data_bus_oe_o) |-> in2_q.reverse_acknowledge_line)
      else $error("bus driven without permission"); // see RULE15
   a_rev_request: assert property (@(posedge clock_i) disable iff (reset_i)
      rev_act |-> !pins_o.reverse_request_line) else $error("reverse request not low"); // see RULE16
   a_strobe_after_ready: assert property (@(posedge clock_i) disable iff (reset_i)
      (fs_q == F_SETUP && !in2_q.peripheral_acknowledge) |=> !stb_q ##1 !stb_q || $rose(stb_q))
      else $error("strobe not asserted on ready"); // see RULE8
   a_flags_track: assert property (@(posedge clock_i) disable iff (reset_i)
      (f_cnt == 5'h10) == !f_ready && (f_cnt == 5'h00) == !f_valid)
      else $error("fifo flags disagree with count"); // see RULE23
   a_rle_not_data: assert property (@(posedge clock_i) disable iff (reset_i)
      (rs_q == R_REQ && !in2_q.peripheral_clock_line && !in2_q.peripheral_acknowledge
       && !pd2_q[7]) |=> rle_q && !pend_q && rep_q == $past(pd2_q[6:0]))
      else $error("run-length byte treated as data"); // see RULE6
   a_error_irq: assert property (@(posedge clock_i) disable iff (reset_i)
      (ecp_m && !dir && !mask_q && !in2_q.peripheral_request_line) |=> error_irq_o)
      else $error("error interrupt missing"); // see RULE18
   a_fwd_cmd_tag: assert property (@(posedge clock_i) disable iff (reset_i)
      (ecp_m && !dir && fs_q == F_STB) |-> pins_o.host_acknowledge_line == !out_q.cmd)
      else $error("host ack does not tag command"); // see RULE13
   a_rev_req_ack: assert property (@(posedge clock_i) disable iff (reset_i)
      (rev_act && rs_q == R_REQ) |-> !pins_o.host_acknowledge_line)
      else $error("reverse byte not requested"); // see RULE12
   a_dma_gate: assert property (@(posedge clock_i) disable iff (reset_i)
      dma_req_o |-> transfer_dma_enable_q && !serv_q && (fwd_act || rev_act))
      else $error("dma request without enable"); // see RULE4
endmodule
`default_nettype wire

// file: tb/ecpp_periph_model.sv
// peripheral model facing the parallel port pins
`timescale 1ns/1ns
`default_nettype none
module ecpp_periph_model (
   input  wire logic                    clock_i,
   input  wire logic [3:0]              delay_i,
   input  wire logic                    req_i,
   input  wire ecpp_pkg::ecpp_pin_out_t pins_o,
   input  wire logic [7:0]              port_data_bus_o,
   input  wire logic                    port_data_bus_oe_o,
   output var  ecpp_pkg::ecpp_pin_in_t  pins_i,
   output var  logic [7:0]              port_data_bus_i
);
   import ecpp_pkg::*;
   ecpp_word_t fwd_q[$];
   ecpp_word_t rev_q[$];
   ecpp_word_t w;
   logic       busy_q  = 1'b0;
   logic       pclk_q  = 1'b1;
   logic       rack_q  = 1'b1;
   logic       drive_q = 1'b0;
   logic [7:0] dout_q  = 8'h00;
   logic [7:0] last_q  = 8'h00;

   // a released bus shows the inverse of its last level
   assign port_data_bus_i = port_data_bus_oe_o ? port_data_bus_o : (drive_q ? dout_q : ~last_q);
   assign pins_i  = {busy_q, pclk_q, rack_q, 1'b1, ~req_i};

   always @(posedge clock_i) begin
      if (port_data_bus_oe_o || drive_q) last_q <= port_data_bus_i;
   end

   task automatic step();
      @(posedge clock_i);
      #1;
   endtask

   task automatic pause();
      repeat (delay_i) step();
   endtask

   initial begin
      forever begin
         step();
         rack_q = pins_o.reverse_request_line;
         if (!pins_o.host_clock_line) begin
            fwd_q.push_back({!pins_o.host_acknowledge_line, port_data_bus_i});
            pause();
            busy_q = 1'b1;
            while (!pins_o.host_clock_line) step();
            pause();
            busy_q = 1'b0;
         end else if (rev_q.size() != 0 && !rack_q && !pins_o.host_acknowledge_line
                      && pins_o.mode_select_line) begin
            w = rev_q.pop_front();
            dout_q = w.data;
            drive_q = 1'b1;
            busy_q = !w.cmd;
            pause();
            pclk_q = 1'b0;
            while (!pins_o.host_acknowledge_line) step();
            pclk_q = 1'b1;
            drive_q = 1'b0;
            busy_q = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/ecp_parallel_port_tb.sv
// self-checking testbench of the extended capabilities parallel port
`timescale 1ns/1ns
`default_nettype none
module ecp_parallel_port_tb;
   import ecpp_pkg::*;
   logic          clock_i    = 1'b0;
   logic          reset_i    = 1'b1;
   logic [10:0]   io_addr_i  = 11'h000;
   logic          io_wr_i    = 1'b0;
   logic          io_rd_i    = 1'b0;
   logic [7:0]    io_wdata_i = 8'h00;
   logic          dma_ack_i  = 1'b0;
   logic [3:0]    delay_i    = 4'h0;
   logic          req_i      = 1'b0;
   logic [7:0]    io_rdata_o;
   logic [7:0]    port_data_bus_i;
   logic [7:0]    port_data_bus_o;
   logic          dma_req_o;
   logic          port_data_bus_oe_o;
   logic          error_irq_o;
   ecpp_pin_in_t  pins_i;
   ecpp_pin_out_t pins_o;
   int            fails = 0;
   int            samples_checked = 0;
   int            i;

   always #25 clock_i = ~clock_i;

   ecpp_top ecpp_top_i (.clock_i, .reset_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
      .io_rdata_o, .dma_ack_i, .dma_req_o, .pins_i, .port_data_bus_i, .port_data_bus_o, .port_data_bus_oe_o, .pins_o,
      .error_irq_o);
   ecpp_periph_model ecpp_periph_model_i (.clock_i, .delay_i, .req_i, .pins_o, .port_data_bus_o,
      .port_data_bus_oe_o, .pins_i, .port_data_bus_i);

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask

   task automatic acc(input logic [10:0] a, input logic [7:0] d, input logic w, input logic dm);
      cyc(1);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = w;
      io_rd_i = !w;
      dma_ack_i = dm;
      cyc(1);
      io_wr_i = 1'b0;
      io_rd_i = 1'b0;
      dma_ack_i = 1'b0;
   endtask

   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      acc(a, d, 1'b1, 1'b0);
   endtask

   task automatic rd(input logic [10:0] a, input logic [7:0] exp, input string what);
      acc(a, 8'h00, 1'b0, 1'b0);
      chk({1'b0, io_rdata_o}, {1'b0, exp}, what);
   endtask

   task automatic fwd(input logic cmd, input logic [7:0] d);
      chk(ecpp_periph_model_i.fwd_q.pop_front(), {cmd, d}, "forward byte");
   endtask

   // bounded wait for forward bytes to arrive and reverse bytes to leave
   task automatic settle(input int n);
      int k = 0;
      while ((ecpp_periph_model_i.fwd_q.size() < n || ecpp_periph_model_i.rev_q.size() != 0
              || ecpp_periph_model_i.drive_q) && k < 2000) begin
         cyc(1);
         k++;
      end
      if (k == 2000) begin
         fails++;
         $display("MISMATCH t=%0t link stalled", $time);
         summarize();
      end
   endtask

   task automatic test_regs();
      cyc(4);
      chk({5'h00, pins_o}, 9'h00d, "pins");
      chk({6'h00, port_data_bus_oe_o, error_irq_o, dma_req_o}, 9'h004, "idle");
      rd(OFS_ECR, 8'h15, "ecr");
      rd(OFS_STAT, 8'hd8, "status");
      rd(11'h003, 8'h00, "unmapped");
      wr(OFS_CTRL, 8'hf0);
      rd(OFS_CTRL, 8'h30, "ctrl");
      wr(OFS_DATA, 8'ha5);
      cyc(3);
      chk({port_data_bus_oe_o, port_data_bus_o}, 9'h1a5, "latch");
      rd(OFS_DATA, 8'ha5, "pins");
      wr(OFS_ECR, 8'he0);
      rd(OFS_FIFO, CFGA_VALUE, "config a");
      rd(OFS_CFGB, 8'h00, "config b");
      wr(OFS_ECR, 8'h40);
      chk({8'h00, port_data_bus_oe_o}, 9'h001, "oe");
      rd(OFS_CTRL, 8'h30, "ctrl");
      $display("test regs done");
   endtask

   task automatic test_compat();
      wr(OFS_CTRL, 8'h00);
      delay_i = 4'h3;
      for (i = 0; i < 3; i++) wr(OFS_FIFO, 8'(17 * (i + 1)));
      settle(3);
      for (i = 0; i < 3; i++) fwd(1'b0, 8'(17 * (i + 1)));
      cyc(20);
      rd(OFS_ECR, 8'h41, "ecr");
      $display("test compat done");
   endtask

   task automatic test_fifo();
      wr(OFS_ECR, 8'hc0);
      for (i = 0; i < 17; i++) wr(OFS_FIFO, 8'(8'h40 + i));
      rd(OFS_ECR, 8'hc2, "full");
      for (i = 0; i < 17; i++) rd(OFS_FIFO, 8'(8'h40 + (i < 16 ? i : 15)), "order");
      rd(OFS_ECR, 8'hc1, "empty");
      $display("test fifo done");
   endtask

   task automatic test_ecp();
      wr(OFS_ECR, 8'h60);
      wr(OFS_CTRL, 8'h08);
      chk({8'h00, pins_o.mode_select_line}, 9'h001, "mode sel");
      chk({8'h00, pins_o.reverse_request_line}, 9'h001, "rev req");
      delay_i = 4'h5;
      wr(OFS_DATA, 8'h12);
      wr(OFS_FIFO, 8'h34);
      wr(OFS_FIFO, 8'h56);
      settle(3);
      fwd(1'b1, 8'h12);
      fwd(1'b0, 8'h34);
      fwd(1'b0, 8'h56);
      cyc(30);
      req_i = 1'b1;
      cyc(6);
      chk({8'h00, error_irq_o}, 9'h001, "irq");
      rd(OFS_STAT, 8'hf0, "status");
      wr(OFS_ECR, 8'h70);
      cyc(2);
      chk({8'h00, error_irq_o}, 9'h000, "masked");
      req_i = 1'b0;
      $display("test ecp done");
   endtask

   task automatic test_dma();
      wr(OFS_ECR, 8'h60);
      delay_i = 4'hf;
      for (i = 0; i < 4; i++) wr(OFS_FIFO, 8'(8'hb0 + i));
      wr(OFS_ECR, 8'h68);
      chk({8'h00, dma_req_o}, 9'h001, "dma req");
      acc(OFS_STAT, 8'h9a, 1'b1, 1'b1);
      settle(5);
      for (i = 0; i < 4; i++) fwd(1'b0, 8'(8'hb0 + i));
      fwd(1'b0, 8'h9a);
      cyc(4);
      chk({8'h00, dma_req_o}, 9'h000, "dma drained");
      rd(OFS_ECR, 8'h6d, "service");
      wr(OFS_ECR, 8'h60);
      rd(OFS_ECR, 8'h65, "service held");
      wr(OFS_ECR, 8'h60);
      $display("test dma done");
   endtask

   task automatic test_rev();
      delay_i = 4'h0;
      wr(OFS_CTRL, 8'h20);
      chk({8'h00, pins_o.reverse_request_line}, 9'h000, "rev req");
      ecpp_periph_model_i.rev_q.push_back({1'b1, 8'h03});
      ecpp_periph_model_i.rev_q.push_back({1'b0, 8'h77});
      ecpp_periph_model_i.rev_q.push_back({1'b0, 8'h88});
      settle(0);
      cyc(10);
      for (i = 0; i < 4; i++) rd(OFS_FIFO, 8'h77, "run");
      rd(OFS_FIFO, 8'h88, "rev");
      rd(OFS_ECR, 8'h61, "ecr");
      $display("test reverse done");
   endtask

   always @(posedge clock_i) begin
      if (ecpp_periph_model_i.drive_q && port_data_bus_oe_o !== 1'b0) begin
         fails++;
         $display("MISMATCH t=%0t bus driven from both ends", $time);
      end
   end

   initial begin
      cyc(16);
      reset_i = 1'b0;
      test_regs();
      test_compat();
      test_fifo();
      test_ecp();
      test_dma();
      test_rev();
      summarize();
   end
endmodule
`default_nettype wire
